// >>> common/sksq_pkg.sv
// Package for the stop key run sequencer: map, fields, timing, structs
package sksq_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int OVERLAP_MS = 60;
    localparam int OVERLAP_CYC = (CLK_HZ / 1000) * OVERLAP_MS;
    localparam int PERMIT_MS = 4;
    localparam int PERMIT_CYC = (CLK_HZ / 1000) * PERMIT_MS;
    localparam int CNT_W = 21;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    localparam int CTRL_STOP_ALWAYS = 0;
    localparam int CTRL_DIR_ALLOW = 1;
    localparam int CTRL_RUN_PERMIT = 2;
    localparam int CTRL_LATCH_SEL = 3;
    localparam int CTRL_SPIN_CATCH = 4;
    localparam int CTRL_KEYPAD_MODE = 5;
    localparam int CTRL_CLOSED_LOOP = 6;

    localparam int ST_RUN = 0;
    localparam int ST_INHIBIT = 1;
    localparam int ST_TRIP = 2;
    localparam int ST_UV = 3;
    localparam int ST_REVERSE = 4;
    localparam int ST_ENABLED = 5;

    localparam int EV_STOP_KEY = 0;
    localparam int EV_TRIP_RESET = 1;
    localparam int EV_RELEASE = 2;
    localparam int EV_UV = 3;
    localparam int EV_W = 4;

    localparam logic [6:0] CTRL_RESET = 7'h44;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_INHIBIT = 3'b100
    } sksq_seq_t;

    typedef struct packed {
        logic runFwd;
        logic runRev;
        logic runSeq;
        logic notStop;
        logic stopKey;
        logic runKey;
        logic dirKey;
        logic tripIn;
        logic underVolt;
        logic hwRunPermit;
    } sksq_cmd_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } sksq_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } sksq_bus_rsp_t;
endpackage

// >>> rtl/sksq_sequencer.sv
// Stop key run sequencer with run inhibit latch and register slave
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module sksq_sequencer (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire sksq_pkg::sksq_cmd_t cmdIn,
    input wire logic [15:0] motorSpeed,
    input wire logic [15:0] requestRef,
    input wire sksq_pkg::sksq_bus_req_t busReq,
    output sksq_pkg::sksq_bus_rsp_t busRsp,
    output logic driveRun,
    output logic driveReverse,
    output logic tripClear,
    output logic [15:0] postRampRef,
    output logic irq
);
    import sksq_pkg::*;

    typedef struct packed {
        sksq_cmd_t sync1;
        sksq_cmd_t sync2;
        sksq_cmd_t prev;
        logic [6:0] ctrl;
        logic permitSampled;
        logic [CNT_W-1:0] permitCnt;
        logic [CNT_W-1:0] overlapCnt;
        sksq_seq_t seq;
        logic fwdLatch;
        logic revLatch;
        logic reverse;
        logic tripped;
        logic [EV_W-1:0] irqStat;
        logic [EV_W-1:0] irqMask;
        sksq_bus_rsp_t rsp;
        logic ack;
        logic tripClear;
        logic [15:0] postRampRef;
        logic irq;
        logic driveRun;
    } sksq_state_t;

    sksq_state_t st;
    sksq_state_t next_st;

    always_comb begin
        sksq_cmd_t c;
        logic stopPress;
        logic runPress;
        logic dirPress;
        logic stopActive;
        logic keypad;
        logic enabled;
        logic overlapDone;
        logic releaseOk;
        logic runReq;
        logic resetNoStop;
        logic [EV_W-1:0] events;
        logic [31:0] rdata;
        c = st.sync2;
        next_st = st;
        next_st.sync1 = cmdIn;
        next_st.sync2 = st.sync1;
        next_st.prev = c;
        keypad = st.ctrl[CTRL_KEYPAD_MODE];
        stopPress = c.stopKey & ~st.prev.stopKey;
        runPress = c.runKey & ~st.prev.runKey;
        dirPress = c.dirKey & ~st.prev.dirKey;
        events = '0;

        // Permit bit read on a 4 ms tick
        if (st.permitCnt == CNT_W'(PERMIT_CYC - 1)) begin
            next_st.permitCnt = '0;
            next_st.permitSampled = st.ctrl[CTRL_RUN_PERMIT];
        end else begin
            next_st.permitCnt = st.permitCnt + CNT_W'(1);
        end
        enabled = st.permitSampled & c.hwRunPermit;

        // Latched mode holds run direction until not-stop drops
        if (st.ctrl[CTRL_LATCH_SEL]) begin
            next_st.fwdLatch = c.notStop & (st.fwdLatch | c.runFwd);
            next_st.revLatch = c.notStop & (st.revLatch | c.runRev);
        end else begin
            next_st.fwdLatch = c.runFwd;
            next_st.revLatch = c.runRev;
        end

        if (c.runFwd & c.runRev) begin
            if (st.overlapCnt != CNT_W'(OVERLAP_CYC)) begin
                next_st.overlapCnt = st.overlapCnt + CNT_W'(1);
            end
        end else begin
            next_st.overlapCnt = '0;
        end
        overlapDone = st.overlapCnt == CNT_W'(OVERLAP_CYC);

        if (st.ctrl[CTRL_LATCH_SEL]) begin
            releaseOk = ~(st.fwdLatch | st.revLatch | c.runSeq)
                | ~c.notStop | ~enabled | overlapDone | c.underVolt;
        end else begin
            releaseOk = ~(c.runFwd | c.runRev | c.runSeq)
                | ~enabled | overlapDone | c.underVolt;
        end

        stopActive = st.ctrl[CTRL_STOP_ALWAYS] | keypad;
        resetNoStop = keypad & c.runKey & stopPress;

        // Undervoltage trip resets only by itself
        // Trip held when undervoltage appears drops while the supply is low, unless tripIn is still high
        next_st.tripped = c.tripIn
            | (st.tripped & ~c.underVolt & ~st.prev.underVolt);
        next_st.tripClear = 1'b0;
        if (st.tripped & stopPress & ~c.underVolt) begin
            next_st.tripped = c.tripIn;
            next_st.tripClear = 1'b1;
            events[EV_TRIP_RESET] = 1'b1;
        end
        if (c.underVolt & ~st.prev.underVolt) begin
            events[EV_UV] = 1'b1;
        end

        if (keypad & st.ctrl[CTRL_DIR_ALLOW] & dirPress) begin
            next_st.reverse = ~st.reverse;
        end else if (~keypad) begin
            next_st.reverse = st.fwdLatch ? 1'b0 : st.revLatch;
        end

        if (keypad) begin
            runReq = (st.seq == SEQ_RUN) | runPress;
        end else begin
            runReq = (st.fwdLatch | st.revLatch | c.runSeq)
                & c.notStop;
        end
        runReq = runReq & enabled & ~st.tripped;

        unique case (st.seq)
            SEQ_IDLE: begin
                // Stop press alone never starts a run
                if (runReq & ~stopPress) begin
                    next_st.seq = SEQ_RUN;
                end else if (stopPress & (stopActive | st.tripped)) begin
                    next_st.seq = SEQ_INHIBIT;
                end
            end
            SEQ_RUN: begin
                if (stopPress & stopActive & ~resetNoStop) begin
                    next_st.seq = SEQ_INHIBIT;
                end else if (~runReq) begin
                    next_st.seq = SEQ_IDLE;
                end
            end
            SEQ_INHIBIT: begin
                if (releaseOk) begin
                    next_st.seq = SEQ_IDLE;
                    events[EV_RELEASE] = 1'b1;
                end
            end
        endcase
        next_st.driveRun = next_st.seq == SEQ_RUN;
        if (stopPress & (stopActive | st.tripped)) begin
            events[EV_STOP_KEY] = 1'b1;
        end

        // Start reference: zero or catch measured speed
        if (~driveRun_c(st.seq) & (next_st.seq == SEQ_RUN)
                & st.ctrl[CTRL_CLOSED_LOOP]) begin
            next_st.postRampRef = st.ctrl[CTRL_SPIN_CATCH]
                ? motorSpeed : 16'h0000;
        end else if (st.seq == SEQ_RUN) begin
            if (st.postRampRef < requestRef) begin
                next_st.postRampRef = st.postRampRef + 16'h0001;
            end else if (st.postRampRef > requestRef) begin
                next_st.postRampRef = st.postRampRef - 16'h0001;
            end
        end else begin
            next_st.postRampRef = 16'h0000;
        end

        // Avalon slave: one wait cycle, then answer
        rdata = UNMAPPED_DATA;
        unique case (busReq.address)
            ADDR_CTRL: rdata = {25'h0000000, st.ctrl};
            ADDR_STATUS: rdata = {26'h0000000, enabled, st.reverse,
                c.underVolt, st.tripped, st.seq == SEQ_INHIBIT,
                st.seq == SEQ_RUN};
            ADDR_IRQ_STAT: rdata = {28'h0000000, st.irqStat};
            ADDR_IRQ_MASK: rdata = {28'h0000000, st.irqMask};
            default: rdata = UNMAPPED_DATA;
        endcase
        next_st.ack = 1'b0;
        next_st.rsp.waitrequest = 1'b1;
        next_st.irqStat = st.irqStat | events;
        if ((busReq.read | busReq.write) & ~st.ack) begin
            next_st.ack = 1'b1;
            next_st.rsp.waitrequest = 1'b0;
            next_st.rsp.readdata = busReq.read ? rdata : 32'h00000000;
            if (busReq.write) begin
                unique case (busReq.address)
                    ADDR_CTRL: next_st.ctrl = busReq.writedata[6:0];
                    ADDR_IRQ_STAT: next_st.irqStat = (st.irqStat
                        & ~busReq.writedata[EV_W-1:0]) | events;
                    ADDR_IRQ_MASK:
                        next_st.irqMask = busReq.writedata[EV_W-1:0];
                    default: next_st.ack = 1'b1;
                endcase
            end
        end
        next_st.irq = |(next_st.irqStat & next_st.irqMask);
    end

    function automatic logic driveRun_c(input sksq_seq_t s);
        driveRun_c = s == SEQ_RUN;
    endfunction

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.permitSampled <= 1'b1;
            st.seq <= SEQ_IDLE;
            st.rsp.waitrequest <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign busRsp = st.rsp;
    assign driveRun = st.driveRun;
    assign driveReverse = st.reverse;
    assign tripClear = st.tripClear;
    assign postRampRef = st.postRampRef;
    assign irq = st.irq;
endmodule

// >>> tb/sksq_properties.sv
// Port checker for the stop key run sequencer
`timescale 1ns/1ps
module sksq_properties (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire sksq_pkg::sksq_cmd_t cmdIn,
    input wire sksq_pkg::sksq_bus_req_t busReq,
    input wire sksq_pkg::sksq_bus_rsp_t busRsp,
    input wire logic driveRun,
    input wire logic tripClear,
    input wire logic [15:0] postRampRef
);
    import sksq_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wait_one_a: assert property (!busRsp.waitrequest |=> busRsp.waitrequest)
        else $error("answer held too long");
    answer_time_a: assert property ((busReq.read || busReq.write)
        && busRsp.waitrequest && $past(busRsp.waitrequest)
        |=> !busRsp.waitrequest) else $error("answer late");
    bus_cause_a: assert property (!busRsp.waitrequest
        |-> $past(busReq.read || busReq.write)) else $error("answer unasked");
    pulse_clear_a: assert property (tripClear |=> !tripClear)
        else $error("trip clear too long");
    clear_cause_a: assert property (
        tripClear |-> $past(cmdIn.stopKey, 3) && !$past(cmdIn.underVolt, 3))
        else $error("trip clear without stop key");
    run_cause_a: assert property (
        $rose(driveRun) |-> $past(cmdIn.hwRunPermit && (cmdIn.runFwd
        || cmdIn.runRev || cmdIn.runSeq || cmdIn.runKey), 3))
        else $error("start without run command");
    permit_off_a: assert property (
        !cmdIn.hwRunPermit [*8] |-> !driveRun) else $error("run unpermitted");
    ramp_step_a: assert property (
        driveRun && $past(driveRun) && $past(driveRun, 2)
        |-> 16'(postRampRef - $past(postRampRef))
        inside {16'h0000, 16'h0001, 16'hffff}) else $error("ramp step");
endmodule
bind sksq_sequencer sksq_properties i_sksq_properties (
    .ref_clk(ref_clk), .rstn(rstn), .cmdIn(cmdIn), .busReq(busReq),
    .busRsp(busRsp), .driveRun(driveRun), .tripClear(tripClear),
    .postRampRef(postRampRef));

// >>> tb/sksq_keypad.sv
// Keypad and command bit source facing the sequencer
`timescale 1ns/1ps
module sksq_keypad (
    input wire logic ref_clk,
    output sksq_pkg::sksq_cmd_t cmdOut
);
    import sksq_pkg::*;
    initial begin
        cmdOut = '0;
        cmdOut.notStop = 1'b1;
        cmdOut.hwRunPermit = 1'b1;
    end
    // Held long enough to pass the input synchroniser
    task automatic press_stop();
        @(posedge ref_clk);
        cmdOut.stopKey <= 1'b1;
        repeat (8) @(posedge ref_clk);
        cmdOut.stopKey <= 1'b0;
    endtask
    task automatic run_fwd(input logic on);
        @(posedge ref_clk);
        cmdOut.runFwd <= on;
    endtask
    task automatic set_fault(input logic trip, input logic uv,
                             input logic perm);
        @(posedge ref_clk);
        cmdOut.tripIn <= trip;
        cmdOut.underVolt <= uv;
        cmdOut.hwRunPermit <= perm;
    endtask
endmodule

// >>> tb/sksq_sequencer_tb.sv
// Self-checking bench for the stop key run sequencer
`timescale 1ns/1ps
module sksq_sequencer_tb;
    import sksq_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sksq_cmd_t cmdIn;
    sksq_bus_req_t busReq = '0;
    sksq_bus_rsp_t busRsp;
    logic driveRun, driveReverse, tripClear, irq;
    logic [15:0] motorSpeed = 16'h0000;
    logic [15:0] requestRef = 16'h0000;
    logic [15:0] postRampRef;
    logic [31:0] expQ[$];
    int mismatches = 0;
    int nChecks = 0;
    int clears = 0;
    int seed = 32'h7e0f72e9;
    initial forever #25 ref_clk = ~ref_clk;
    sksq_keypad i_sksq_keypad (.ref_clk(ref_clk), .cmdOut(cmdIn));
    sksq_sequencer i_sksq_sequencer (
        .ref_clk(ref_clk), .rstn(rstn), .cmdIn(cmdIn),
        .motorSpeed(motorSpeed), .requestRef(requestRef), .busReq(busReq),
        .busRsp(busRsp), .driveRun(driveRun), .driveReverse(driveReverse),
        .tripClear(tripClear), .postRampRef(postRampRef), .irq(irq));
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Read: d is the expected word, answered later by the monitor
    task automatic bus(input logic [3:0] a, input logic wr,
                       input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        busReq <= '{address: a, read: !wr, write: wr, writedata: d};
        if (!wr) expQ.push_back(d);
        // Look between edges; the answer stands up to the next rise
        do begin
            @(negedge ref_clk);
            n++;
        end while (busRsp.waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
        @(posedge ref_clk);
        busReq.read <= 1'b0;
        busReq.write <= 1'b0;
    endtask
    task automatic settle();
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    always @(negedge ref_clk) begin
        if (busReq.read && busRsp.waitrequest === 1'b0 && expQ.size() > 0)
            chk("readdata", expQ.pop_front(), busRsp.readdata);
        if (tripClear === 1'b1) clears++;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end
    initial begin
        motorSpeed = 16'($random(seed));
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        bus(ADDR_CTRL, 1'b0, {25'h0, CTRL_RESET});
        bus(4'h2, 1'b0, UNMAPPED_DATA);
        bus(4'h2, 1'b1, 32'hffffffff);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h0000000f);
        bus(ADDR_CTRL, 1'b1, 32'h00000045);
        bus(ADDR_CTRL, 1'b0, 32'h00000045);
        requestRef <= 16'h0400;
        i_sksq_keypad.run_fwd(1'b1);
        settle();
        chk("driveRun", 32'h1, {31'h0, driveRun});
        chk("rampStart", 32'h1, {31'h0, postRampRef < 16'h0010});
        chk("driveReverse", 32'h0, {31'h0, driveReverse});
        i_sksq_keypad.press_stop();
        chk("driveRun", 32'h0, {31'h0, driveRun});
        chk("irq", 32'h1, {31'h0, irq});
        bus(ADDR_IRQ_STAT, 1'b0, 32'h00000001);
        bus(ADDR_IRQ_STAT, 1'b1, 32'h00000001);
        settle();
        chk("irq", 32'h0, {31'h0, irq});
        chk("driveRun", 32'h0, {31'h0, driveRun});
        i_sksq_keypad.run_fwd(1'b0);
        settle();
        i_sksq_keypad.run_fwd(1'b1);
        settle();
        chk("driveRun", 32'h1, {31'h0, driveRun});
        // Stop key disabled from here: only the trip path acts
        bus(ADDR_CTRL, 1'b1, 32'h00000044);
        i_sksq_keypad.set_fault(1'b1, 1'b0, 1'b1);
        settle();
        i_sksq_keypad.press_stop();
        i_sksq_keypad.set_fault(1'b0, 1'b0, 1'b1);
        settle();
        chk("tripClear", 32'h1, clears);
        chk("driveRun", 32'h0, {31'h0, driveRun});
        i_sksq_keypad.set_fault(1'b1, 1'b1, 1'b1);
        settle();
        i_sksq_keypad.press_stop();
        chk("tripClear", 32'h1, clears);
        i_sksq_keypad.run_fwd(1'b0);
        i_sksq_keypad.set_fault(1'b0, 1'b0, 1'b1);
        bus(ADDR_CTRL, 1'b1, 32'h00000054);
        requestRef <= motorSpeed;
        settle();
        i_sksq_keypad.run_fwd(1'b1);
        settle();
        chk("postRampRef", {16'h0, motorSpeed}, {16'h0, postRampRef});
        i_sksq_keypad.set_fault(1'b0, 1'b0, 1'b0);
        settle();
        chk("driveRun", 32'h0, {31'h0, driveRun});
        end_sim();
    end
endmodule
